/* hdl/asp_host.sv */
// host controller driving a 512k x 32 asynchronous static memory
`timescale 1ns/1ps
`default_nettype none

module asp_host #(
    parameter int POWER_UP_CYCLES = asp_pkg::POWER_UP_CYCLES,
    parameter int READ_CYCLES     = asp_pkg::READ_CYCLES,
    parameter int WRITE_CYCLES    = asp_pkg::WRITE_CYCLES
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    // user request side
    input  wire logic                       req_valid,
    input  wire logic                       req_write,
    input  wire logic [asp_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [asp_pkg::DATA_W-1:0] req_wdata,
    input  wire logic [asp_pkg::LANES-1:0]  req_lanes,
    output var  logic                       req_ready,
    output var  logic                       rsp_valid,
    output var  logic [asp_pkg::DATA_W-1:0] rsp_rdata,
    output var  logic                       powered_up,
    // memory pins
    output var  logic [asp_pkg::ADDR_W-1:0] mem_addr,
    output var  logic                       chip_select_n_first,
    output var  logic                       chip_select_n_second,
    output var  logic                       chip_select_n_third,
    output var  logic                       output_enable_n,
    output var  logic                       write_strobe_n,
    output var  logic                       lane_select_n_byte0,
    output var  logic                       lane_select_n_byte1,
    output var  logic                       lane_select_n_byte2,
    output var  logic                       lane_select_n_byte3,
    input  wire logic [asp_pkg::DATA_W-1:0] mem_data_in,
    output var  logic [asp_pkg::DATA_W-1:0] mem_data_out,
    output var  logic                       mem_data_oe
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    localparam int PW = 20;
    if (READ_CYCLES < 1 || READ_CYCLES > 200 || WRITE_CYCLES < 2 ||
        WRITE_CYCLES > 200 || POWER_UP_CYCLES < 1 ||
        POWER_UP_CYCLES >= (1 << PW)) begin : g_bad_timing
        $error("asp_host: timing parameter out of range");
    end

    typedef enum logic [2:0] {
        ASP_POWER, ASP_IDLE, ASP_READ, ASP_WRITE, ASP_TURN
    } asp_state_t;

    asp_state_t                  state;
    asp_state_t                  next_state;
    logic [PW-1:0]               pu_cnt;
    logic [asp_pkg::CNT_W-1:0]   cnt;
    logic [asp_pkg::DATA_W-1:0]  rd_sync;
    logic [asp_pkg::LANES-1:0]   lanes_n;
    logic [asp_pkg::DATA_W-1:0]  lane_mask;

    // lane mask: byte lane i selected expands to 8 data bits
    function automatic logic [asp_pkg::DATA_W-1:0] lane_bits(
        input logic [asp_pkg::LANES-1:0] sel_n);
        logic [asp_pkg::DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < asp_pkg::LANES; i++) begin
            m[i*8 +: 8] = {8{~sel_n[i]}};
        end
        return m;
    endfunction

    // ------------------------------------------------------------------
    // read data passes the three-stage sampler, pins are asynchronous
    // ------------------------------------------------------------------
    asp_sync #(.W(asp_pkg::DATA_W)) u_rd_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .d     (mem_data_in),
        .q     (rd_sync)
    );

    // ------------------------------------------------------------------
    // decode of the sequencer
    // ------------------------------------------------------------------
    wire logic pu_done   = (pu_cnt == PW'(POWER_UP_CYCLES));
    wire logic take      = (state == ASP_IDLE) && req_valid;
    // sampler adds three cycles of latency on top of access time
    wire logic rd_done   = (state == ASP_READ) &&
                           (cnt == asp_pkg::CNT_W'(READ_CYCLES + 3));
    wire logic wr_done   = (state == ASP_WRITE) &&
                           (cnt == asp_pkg::CNT_W'(WRITE_CYCLES));
    wire logic sel_n     = ~(take || (state == ASP_READ && !rd_done) ||
                             (state == ASP_WRITE && !wr_done));

    always_comb begin
        next_state = state;
        case (state)
            ASP_POWER: if (pu_done) next_state = ASP_IDLE;
            ASP_IDLE:  if (req_valid) begin
                next_state = req_write ? ASP_WRITE : ASP_READ;
            end
            ASP_READ:  if (rd_done) next_state = ASP_TURN;
            ASP_WRITE: if (wr_done) next_state = ASP_TURN;
            ASP_TURN:  next_state = ASP_IDLE;
            default:   next_state = ASP_POWER;
        endcase
    end

    // ------------------------------------------------------------------
    // state, counters and power-up wait
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state  <= ASP_POWER;
            pu_cnt <= '0;
            cnt    <= '0;
        end else if (ce) begin
            state <= next_state;
            if (!pu_done) pu_cnt <= pu_cnt + 1'b1;
            cnt <= (state != next_state) ? '0 : cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // pin drive: all chip selects move together so the write ends on one
    // edge of all of them and the strobe, keeping setup unambiguous
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chip_select_n_first  <= 1'b1;
            chip_select_n_second <= 1'b1;
            chip_select_n_third  <= 1'b1;
            output_enable_n      <= 1'b1;
            write_strobe_n       <= 1'b1;
            lanes_n              <= '1;
            mem_addr             <= '0;
            mem_data_out         <= '0;
            mem_data_oe          <= 1'b0;
        end else if (ce) begin
            chip_select_n_first  <= sel_n;
            chip_select_n_second <= sel_n;
            chip_select_n_third  <= sel_n;
            // strobe ends with the selects; lanes, address, data held
            write_strobe_n  <= ~((take && req_write) ||
                                 (state == ASP_WRITE && !wr_done));
            // outputs enabled only for reads, bus released first
            output_enable_n <= ~((take && !req_write) ||
                                 (state == ASP_READ && !rd_done));
            if (take) begin
                mem_addr     <= req_addr;
                lanes_n      <= ~req_lanes;
                mem_data_out <= req_wdata;
            end
            // drive only during writes, never with outputs on
            mem_data_oe <= (take && req_write) ||
                           (state == ASP_WRITE && !wr_done);
        end
    end

    assign lane_select_n_byte0 = lanes_n[0];
    assign lane_select_n_byte1 = lanes_n[1];
    assign lane_select_n_byte2 = lanes_n[2];
    assign lane_select_n_byte3 = lanes_n[3];
    assign lane_mask           = lane_bits(lanes_n);

    // ------------------------------------------------------------------
    // user answer: unselected lanes read as zero (they float)
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rsp_valid  <= 1'b0;
            rsp_rdata  <= '0;
            req_ready  <= 1'b0;
            powered_up <= 1'b0;
        end else if (ce) begin
            rsp_valid  <= rd_done;
            if (rd_done) rsp_rdata <= rd_sync & lane_mask;
            req_ready  <= (next_state == ASP_IDLE) && !take;
            powered_up <= pu_done || powered_up;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_power_wait_first: assert property (
        @(posedge clk) disable iff (!rst_n)
        !chip_select_n_first |-> pu_done)
        else $error("access before power-up wait");

    chk_no_contention: assert property (
        @(posedge clk) disable iff (!rst_n)
        !(mem_data_oe && !output_enable_n))
        else $error("host drives bus with memory outputs on");

    chk_selects_together: assert property (
        @(posedge clk) disable iff (!rst_n)
        (chip_select_n_first == chip_select_n_second) &&
        (chip_select_n_second == chip_select_n_third))
        else $error("chip selects split");

    chk_write_strobe_len: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        $fell(write_strobe_n) |-> !write_strobe_n [*2])
        else $error("write strobe too short");

    chk_write_holds_addr: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!write_strobe_n && !$past(write_strobe_n)) |->
        ($stable(mem_addr) && $stable(mem_data_out) && $stable(lanes_n)))
        else $error("address, data or lanes moved during write");

    chk_write_end_joint: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(write_strobe_n) |-> $rose(chip_select_n_first))
        else $error("write not ended on joint edge");

    chk_read_answer: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        $fell(output_enable_n) |-> ##[1:250] rsp_valid)
        else $error("read answer missing");

    chk_strobe_no_oe: assert property (
        @(posedge clk) disable iff (!rst_n)
        !write_strobe_n |-> output_enable_n)
        else $error("output enable during write");

endmodule

`default_nettype wire

/* hdl/asp_sync.sv */
// three-stage input synchroniser with agreement check
`timescale 1ns/1ps
`default_nettype none

module asp_sync #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    wire  logic [W-1:0] agree;

    // ------------------------------------------------------------------
    // sampling chain; s1 is read only by s2 to keep metastability out
    // ------------------------------------------------------------------
    // per bit: a floating lane that toggles must not stall the others
    assign agree = ~(s2 ^ s3);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q  <= '0;
        end else if (ce) begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q  <= (s3 & agree) | (q & ~agree);  // bit moves once agreed
        end
    end

endmodule

`default_nettype wire

/* pkg/asp_pkg.sv */
// package of constants for the asynchronous sram host controller
package asp_pkg;

    // ------------------------------------------------------------------
    // clock and geometry
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 10000;   // 100 MHz
    localparam int ADDR_W        = 19;
    localparam int DATA_W        = 32;
    localparam int LANES         = 4;
    localparam int WORDS         = 524288;

    // ------------------------------------------------------------------
    // timing figures as printed (ps; power-up wait in ms)
    // ------------------------------------------------------------------
    localparam int POWER_UP_WAIT_MS           = 1;
    localparam int ADDRESS_ACCESS_TIME_PS     = 12000; // slowest grade
    localparam int OUTPUT_ENABLE_ACCESS_PS    = 6000;
    localparam int SELECT_ACCESS_TIME_PS      = 12000;
    localparam int OUTPUT_HOLD_AFTER_ADDR_PS  = 3000;
    localparam int WRITE_ADDRESS_SETUP_PS     = 8000;
    localparam int WRITE_DATA_SETUP_PS        = 6000;
    localparam int LANE_SELECT_TO_WRITE_END_PS = 8000;
    localparam int STROBE_LOW_TO_FLOAT_PS     = 6000;

    // ------------------------------------------------------------------
    // cycle counts: least times round up, never below one
    // ------------------------------------------------------------------
    function automatic int cyc_up(input int ps);
        int c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int POWER_UP_CYCLES =
        POWER_UP_WAIT_MS * (1000000000 / CLK_PERIOD_PS);
    // read sample point: covers address, select and enable access
    localparam int READ_CYCLES  = cyc_up(ADDRESS_ACCESS_TIME_PS);
    // strobe low phase: strobe-low-to-float time plus data setup
    localparam int WRITE_CYCLES = cyc_up(STROBE_LOW_TO_FLOAT_PS
                                         + WRITE_DATA_SETUP_PS);
    localparam int TURN_CYCLES  = 1;        // bus turnaround gap
    localparam int CNT_W        = 8;

endpackage

/* tb/asp_mem_model.sv */
// behavioural model of the 512k x 32 asynchronous static memory
`timescale 1ns/1ps
`default_nettype none

module asp_mem_model #(
    parameter real PWR_NS = 250.0
) (
    input  wire logic [18:0] addr,
    input  wire logic [2:0]  cs_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [3:0]  lane_n,
    input  wire logic [31:0] bus,
    input  wire logic        host_oe,
    output var  logic [31:0] q,
    output var  logic [3:0]  q_en,
    output var  int          viols
);
    // ------------------------------------------------------------------
    // array, decode and delayed copies of the pins
    // ------------------------------------------------------------------
    logic [31:0] mem [0:524287];
    logic [31:0] word;
    logic [31:0] word_w;
    logic [22:0] ad_d;
    logic [31:0] bus_d;
    logic [19:0] key_d;
    logic [19:0] key_h;
    logic [3:0]  lane_d;
    real         t_ad;
    real         t_bd;
    real         t_wr;
    int          wr_cnt;
    wire         sel = ~|cs_n;
    wire         wr  = sel & ~we_n;
    wire         rd  = sel & ~oe_n & we_n;
    // slowest grade figures; the 1 ns copies let the closing edge see old pins
    assign #12 key_d  = {addr, rd};
    // old word stands 3 ns after the address moves
    assign #3  key_h  = {addr, rd};
    assign #6  lane_d = lane_n;
    assign #1  ad_d   = {addr, lane_n};
    assign #1  bus_d  = bus;
    wire         valid = (key_d == key_h) && (lane_d == lane_n);

    // ------------------------------------------------------------------
    // read side: garbage until access time has passed
    // ------------------------------------------------------------------
    assign q_en = {4{rd}} & ~lane_n;
    always @(key_h, valid, wr_cnt) begin
        word = mem[key_h[19:1]];
        q = valid ? word : ~word;
    end

    // ------------------------------------------------------------------
    // write side and checks on the host's timing
    // ------------------------------------------------------------------
    always @(posedge wr) t_wr = $realtime;
    always @(ad_d) t_ad = $realtime;
    always @(bus_d) t_bd = $realtime;
    always @(posedge sel) if ($realtime < PWR_NS) viols++;
    always @(host_oe, q_en) if (host_oe && q_en != 4'h0) viols++;
    // store on whichever control rise closes the write
    always @(negedge wr) begin
        if (t_wr > 0.0) begin
            if ($realtime - t_wr < 12.0) viols++;
            if ($realtime - t_ad + 1.0 < 8.0) viols++;
            if ($realtime - t_bd + 1.0 < 6.0) viols++;
            word_w = mem[ad_d[22:4]];
            for (int i = 0; i < 4; i++)
                if (!ad_d[i]) word_w[8*i +: 8] = bus_d[8*i +: 8];
            mem[ad_d[22:4]] = word_w;
            wr_cnt++;
        end
    end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the asynchronous sram host controller
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int PWR    = 20;
    // access cycles, three sampler stages, then the answer register
    localparam int RD_LAT = asp_pkg::READ_CYCLES + 4;
    logic        clk;
    logic        rst_n;
    logic        ce;
    logic        req_valid;
    logic        req_write;
    logic [18:0] req_addr;
    logic [31:0] req_wdata;
    logic [3:0]  req_lanes;
    logic        req_ready;
    logic        rsp_valid;
    logic [31:0] rsp_rdata;
    logic        powered_up;
    logic [18:0] mem_addr;
    logic [2:0]  cs_n;
    logic        oe_n;
    logic        we_n;
    logic [3:0]  lane_n;
    logic [31:0] mem_data_in;
    logic [31:0] mem_data_out;
    logic        mem_data_oe;
    logic [31:0] q;
    logic [3:0]  q_en;
    logic [31:0] junk;
    logic [31:0] rdat;
    int          viols;
    int          fails;
    int          tests_run;
    int          cyc;

    asp_host #(.POWER_UP_CYCLES(PWR)) dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_lanes(req_lanes), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .powered_up(powered_up), .mem_addr(mem_addr),
        .chip_select_n_first(cs_n[0]), .chip_select_n_second(cs_n[1]),
        .chip_select_n_third(cs_n[2]), .output_enable_n(oe_n),
        .write_strobe_n(we_n), .lane_select_n_byte0(lane_n[0]),
        .lane_select_n_byte1(lane_n[1]), .lane_select_n_byte2(lane_n[2]),
        .lane_select_n_byte3(lane_n[3]), .mem_data_in(mem_data_in),
        .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe)
    );
    asp_mem_model #(.PWR_NS(250.0)) mem (
        .addr(mem_addr), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
        .lane_n(lane_n), .bus(mem_data_in), .host_oe(mem_data_oe),
        .q(q), .q_en(q_en), .viols(viols)
    );

    // --------------------------------------------------------------
    // wire resolution: a released lane shows a pattern that toggles
    // --------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 4; i++)
            mem_data_in[8*i +: 8] = mem_data_oe ? mem_data_out[8*i +: 8]
                : q_en[i] ? q[8*i +: 8] : junk[8*i +: 8];
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // float pattern and hang guard
    always @(posedge clk) begin
        junk <= ~junk;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            end_sim();
        end
    end

    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one request, held until the pins show it was taken
    task automatic op(input logic wr, input logic [18:0] a,
                      input logic [31:0] d, input logic [3:0] ln,
                      input int stall);
        int n;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_lanes = ln;
        req_valid = 1'b1;
        n = 0;
        while (cs_n[0] !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        req_valid = 1'b0;
        chk("pins", 32'({mem_addr, lane_n}), 32'({a, ~ln}));
        chk("ctl", 32'({cs_n, we_n}), 32'({3'b000, ~wr}));
        chk("busy", 32'(req_ready), 32'h0);
        if (wr) begin
            chk("wdat", mem_data_out, d);
            chk("drv", 32'(mem_data_oe), 32'h1);
            n = 0;
            while (cs_n[0] === 1'b0 && n < 50) begin
                @(negedge clk);
                n++;
            end
            chk("wlen", 32'(n), 32'(asp_pkg::WRITE_CYCLES + 1));
            chk("wend", 32'({we_n, cs_n}), 32'hf);
        end else begin
            chk("rdrv", 32'({mem_data_oe, oe_n}), 32'h0);
            if (stall > 0) begin
                ce = 1'b0;
                repeat (stall) @(negedge clk);
                ce = 1'b1;
            end
            n = 0;
            while (rsp_valid !== 1'b1 && n < 50) begin
                @(negedge clk);
                n++;
            end
            chk("rlat", 32'(n), 32'(RD_LAT));
            rdat = rsp_rdata;
            @(negedge clk);
            chk("rpulse", 32'(rsp_valid), 32'h0);
            chk("ready", 32'(req_ready), 32'h1);
        end
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_power();
        req_valid = 1'b1;
        repeat (PWR - 2) begin
            chk("idle", 32'({powered_up, req_ready, cs_n}), 32'h7);
            @(negedge clk);
        end
        op(1'b1, 19'h00000, 32'h01234567, 4'hf, 0);
        chk("up", 32'(powered_up), 32'h1);
        $display("test power done");
    endtask
    task automatic t_edges();
        op(1'b1, 19'h7ffff, 32'hc3a55a3c, 4'hf, 0);
        op(1'b0, 19'h00000, 32'h0, 4'hf, 3);
        chk("lo", rdat, 32'h01234567);
        op(1'b0, 19'h7ffff, 32'h0, 4'hf, 0);
        chk("hi", rdat, 32'hc3a55a3c);
        $display("test edges done");
    endtask
    task automatic t_lanes();
        logic [31:0] e;
        logic [3:0]  ln;
        e = 32'h0;
        op(1'b1, 19'h00009, 32'h0, 4'hf, 0);
        for (int i = 0; i < 4; i++) begin
            e[8*i +: 8] = 8'(32'h8899aabb >> (8 * i));
            op(1'b1, 19'h00009, 32'h8899aabb, 4'(1 << i), 0);
            op(1'b0, 19'h00009, 32'h0, 4'hf, 0);
            chk("wlane", rdat, e);
        end
        for (int i = 0; i < 5; i++) begin
            ln = 4'(1 << i);
            op(1'b0, 19'h00009, 32'h0, ln, 0);
            chk("rlane", rdat, e & {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}},
                {8{ln[0]}}});
        end
        $display("test lanes done");
    endtask
    // write straight into a read of the same word: turnaround on the bus
    task automatic t_b2b();
        logic [31:0] v [2] = '{32'hfeedf00d, 32'h13572468};
        for (int i = 0; i < 2; i++) begin
            op(1'b1, 19'h0002a, v[i], 4'hf, 0);
            op(1'b0, 19'h0002a, 32'h0, 4'hf, 0);
            chk("b2b", rdat, v[i]);
        end
        $display("test back_to_back done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 19'h0;
        req_wdata = 32'h0;
        req_lanes = 4'h0;
        junk = 32'h3c96a5f0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        t_power();
        t_edges();
        t_lanes();
        t_b2b();
        chk("viols", 32'(viols), 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
